// file: include/ssb_pkg.sv
// Shared constants, carrier structs and state types of the sideband pin logic
package ssb_pkg;

    // Payload word layout as handed to the serial framer
    localparam int PAYLOAD_W     = 30;
    localparam int LANE_W        = 21;    // Lanes zero to two, seven bits each
    localparam int FOUR_W        = 7;     // Fourth lane, one LVDS clock
    localparam int FOUR_LO       = 21;
    localparam int FOUR_HI       = 26;
    localparam int RES_IN_FOUR   = 6;     // Panel reserved bit within lane four
    localparam int BIT_CTRL_ONE  = 27;
    localparam int BIT_CTRL_TWO  = 28;
    localparam int BIT_CTRL_ZERO = 29;

    // Spread depth in tenths of a percent, plus or minus
    localparam logic [3:0] SPREAD_DEPTH = 4'h5;
    localparam logic [3:0] SPREAD_NONE  = 4'h0;

    // Reset values
    localparam logic [PAYLOAD_W-1:0] PAYLOAD_RST = 30'h0000_0000;
    localparam logic                 STRAP_RST   = 1'b0;
    localparam logic                 REQUEST_RST = 1'b0;

    // Configuration levels that steer the link-side sampling
    typedef struct packed {
        logic four_lane;     // Bus width select, high for four lanes
        logic audio_on;      // Audio serial input enabled
        logic encrypt_on;    // Content encryption enabled
        logic use_reserved;  // Bit 27 from panel reserved bit, not ctrl one
        logic powered;       // Power-down pin released
    } ssb_cfg_type;

    // Asynchronous pins seen by the core domain
    typedef struct packed {
        logic powered;
        logic strap;
        logic fault;
        logic remote_int;
        logic rx_sda;
        logic tx_scl;
    } ssb_pins_type;

    // Shared receive and transmit pin function
    typedef enum logic {
        SSB_UART     = 1'b0,
        SSB_TWO_WIRE = 1'b1
    } ssb_pin_mode_type;

    // Power sequence of the core domain
    typedef enum logic [1:0] {
        SSB_PWR_DOWN    = 2'b00,
        SSB_PWR_CAPTURE = 2'b01,
        SSB_PWR_RUN     = 2'b10
    } ssb_pwr_type;

endpackage : ssb_pkg

// file: hdl/ssb_sync.sv
// Two-flip-flop level synchroniser of configurable width
module ssb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : ssb_sync

// file: hdl/ssb_toggle.sv
// Request level that inverts on every edge of a synchronised input while run is high
module ssb_toggle (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    input  wire logic level_in,
    // Request level
    output logic      request
);

    logic last_level;
    logic edge_seen;

    assign edge_seen = run && (level_in != last_level);

    // Track the input even when idle, so restart gives no false edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_level <= 1'b0;
        end else begin
            last_level <= level_in;
        end
    end

    // Held low outside run, inverted on each seen edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            request <= ssb_pkg::REQUEST_RST;
        end else if (!run) begin
            request <= ssb_pkg::REQUEST_RST;
        end else if (edge_seen) begin
            request <= ~request;
        end
    end

endmodule : ssb_toggle

// file: hdl/ssb_sideband.sv
// Sideband pin logic of the serializer: link sampling, shared pins, straps
//
// Function
// - Lane four carried only in four-lane mode; otherwise ignored.
// - Audio disabled: shared audio pin sampled each LVDS clock as control.
// - Shared audio/control bit is tagged for encryption when encryption on.
// - Control one sampled each LVDS clock, accepted only in four-lane mode.
// - Control one or panel reserved bit goes to payload bit 27.
// - Control one bit always sent unencrypted.
// - Control two sampled each LVDS clock in four-lane mode into bit 28.
// - Control two bit always sent unencrypted.
// - Shared receive pin: UART receive, or open-drain two-wire data.
// - Shared transmit pin: UART transmit, or open-drain two-wire clock.
// - Spread strap captured only at power-up and power-down release.
// - Captured strap high gives plus/minus 0.5 percent spread, else none.
// - Detected line fault pulls the open-drain fault output low.
// - Fault output released high while power-down is low.
// - Remote request low at power-up and while power-down is low.
// - Each remote interrupt input edge in the run state inverts the remote request.
module ssb_sideband (
    // Core clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    // Link clock and LVDS lane data
    input  wire logic                              lvds_clock_in,
    input  wire logic [ssb_pkg::LANE_W-1:0]        lane_word,
    input  wire logic [ssb_pkg::FOUR_W-1:0]        lvds_lane_four_in,
    // Sideband control pins, timed to the LVDS clock
    input  wire logic                              audio_data_or_ctrl_zero,
    input  wire logic                              ctrl_in_one,
    input  wire logic                              ctrl_in_two,
    // Configuration pins and levels
    input  wire logic                              bus_width_select,
    input  wire logic                              audio_enable,
    input  wire logic                              encrypt_enable,
    input  wire logic                              use_reserved_bit,
    input  wire logic                              power_down_n,
    input  wire logic                              spread_spectrum_strap,
    // Payload toward the serial framer, link domain
    output logic      [ssb_pkg::PAYLOAD_W-1:0]     payload_word,
    output logic      [ssb_pkg::PAYLOAD_W-1:0]     encrypt_mask,
    output logic                                   payload_valid,
    // Status in the core domain
    output logic                                   four_lane_active,
    output logic                                   spread_enable,
    output logic      [3:0]                        spread_amount,
    // Internal UART and two-wire master, core domain
    input  wire logic                              two_wire_mode,
    input  wire logic                              uart_tx,
    output logic                                   uart_rx,
    input  wire logic                              sda_drive_low,
    input  wire logic                              scl_drive_low,
    output logic                                   sda_seen,
    output logic                                   scl_seen,
    // Shared receive / data pin
    input  wire logic                              rx_sda_in,
    output logic                                   rx_sda_out,
    output logic                                   rx_sda_oe,
    // Shared transmit / clock pin
    input  wire logic                              tx_scl_in,
    output logic                                   tx_scl_out,
    output logic                                   tx_scl_oe,
    // Line fault detector and open-drain fault pin
    input  wire logic                              line_fault_detect,
    output logic                                   line_fault_n_out,
    output logic                                   line_fault_n_oe,
    // Remote interrupt input and request output
    input  wire logic                              remote_int_in,
    output logic                                   remote_request
);

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    ssb_pkg::ssb_cfg_type               cfg_pins;
    ssb_pkg::ssb_cfg_type               link_cfg;
    logic [ssb_pkg::PAYLOAD_W-1:0]      next_payload;
    logic [ssb_pkg::PAYLOAD_W-1:0]      next_mask;

    assign cfg_pins = '{four_lane:    bus_width_select,
                        audio_on:     audio_enable,
                        encrypt_on:   encrypt_enable,
                        use_reserved: use_reserved_bit,
                        powered:      power_down_n};

    // Configuration levels cross into the LVDS clock domain
    ssb_sync #(
        .W ($bits(ssb_pkg::ssb_cfg_type))
    ) u_link_sync (
        .clk      (lvds_clock_in),
        .rst      (rst),
        .async_in (cfg_pins),
        .sync_out (link_cfg)
    );

    // Build the payload word from lanes and sideband pins
    always_comb begin
        next_payload = ssb_pkg::PAYLOAD_RST;
        next_mask    = '0;
        next_payload[ssb_pkg::LANE_W-1:0] = lane_word;
        next_mask[ssb_pkg::LANE_W-1:0]    = {ssb_pkg::LANE_W{link_cfg.encrypt_on}};
        if (link_cfg.four_lane) begin
            next_payload[ssb_pkg::FOUR_HI:ssb_pkg::FOUR_LO] =
                lvds_lane_four_in[ssb_pkg::RES_IN_FOUR-1:0];
            next_mask[ssb_pkg::FOUR_HI:ssb_pkg::FOUR_LO] =
                {ssb_pkg::RES_IN_FOUR{link_cfg.encrypt_on}};
            next_payload[ssb_pkg::BIT_CTRL_ONE] = link_cfg.use_reserved ?
                lvds_lane_four_in[ssb_pkg::RES_IN_FOUR] : ctrl_in_one;
            next_payload[ssb_pkg::BIT_CTRL_TWO] = ctrl_in_two;
        end
        next_mask[ssb_pkg::BIT_CTRL_ONE] = 1'b0;
        next_mask[ssb_pkg::BIT_CTRL_TWO] = 1'b0;
        if (!link_cfg.audio_on) begin
            next_payload[ssb_pkg::BIT_CTRL_ZERO] = audio_data_or_ctrl_zero;
        end
        next_mask[ssb_pkg::BIT_CTRL_ZERO] = link_cfg.encrypt_on;
    end

    // One capture per LVDS edge keeps lanes and sideband in one word
    // same-edge sampling
    always_ff @(posedge lvds_clock_in or posedge rst) begin
        if (rst) begin
            payload_word  <= ssb_pkg::PAYLOAD_RST;
            encrypt_mask  <= '0;
            payload_valid <= 1'b0;
        end else if (!link_cfg.powered) begin
            payload_word  <= ssb_pkg::PAYLOAD_RST;
            encrypt_mask  <= '0;
            payload_valid <= 1'b0;
        end else begin
            payload_word  <= next_payload;
            encrypt_mask  <= next_mask;
            payload_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------------
    ssb_pkg::ssb_pins_type  pins_raw;
    ssb_pkg::ssb_pins_type  pins;
    ssb_pkg::ssb_pwr_type   pwr_state;
    ssb_pkg::ssb_pwr_type   next_pwr_state;
    logic                   four_lane_sync;

    assign pins_raw = '{powered:    power_down_n,
                        strap:      spread_spectrum_strap,
                        fault:      line_fault_detect,
                        remote_int: remote_int_in,
                        rx_sda:     rx_sda_in,
                        tx_scl:     tx_scl_in};

    // All pins reach core logic through two flip-flops
    ssb_sync #(
        .W ($bits(ssb_pkg::ssb_pins_type))
    ) u_core_sync (
        .clk      (core_clk),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    // Bus width as the link actually uses it, reported back
    ssb_sync #(
        .W (1)
    ) u_mode_sync (
        .clk      (core_clk),
        .rst      (rst),
        .async_in (link_cfg.four_lane),
        .sync_out (four_lane_sync)
    );
    assign four_lane_active = four_lane_sync;

    // Power sequence: down, one capture cycle, then run
    always_comb begin
        case (pwr_state)
            ssb_pkg::SSB_PWR_DOWN:
                next_pwr_state = pins.powered ? ssb_pkg::SSB_PWR_CAPTURE
                                              : ssb_pkg::SSB_PWR_DOWN;
            ssb_pkg::SSB_PWR_CAPTURE:
                next_pwr_state = pins.powered ? ssb_pkg::SSB_PWR_RUN
                                              : ssb_pkg::SSB_PWR_DOWN;
            ssb_pkg::SSB_PWR_RUN:
                next_pwr_state = pins.powered ? ssb_pkg::SSB_PWR_RUN
                                              : ssb_pkg::SSB_PWR_DOWN;
            default:
                next_pwr_state = ssb_pkg::SSB_PWR_DOWN;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr_state <= ssb_pkg::SSB_PWR_DOWN;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    // Strap taken in the capture cycle only; later pin moves are ignored
    // strap latch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spread_enable <= ssb_pkg::STRAP_RST;
        end else if (pwr_state == ssb_pkg::SSB_PWR_CAPTURE) begin
            spread_enable <= pins.strap;
        end
    end

    assign spread_amount = spread_enable ? ssb_pkg::SPREAD_DEPTH
                                         : ssb_pkg::SPREAD_NONE;

    // Fault pin pulls low only while powered and a fault is seen
    // fault drive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_fault_n_oe <= 1'b0;
        end else begin
            line_fault_n_oe <= pins.powered && pins.fault;
        end
    end
    assign line_fault_n_out = 1'b0;

    ssb_toggle u_request (
        .clk      (core_clk),
        .rst      (rst),
        .run      (pwr_state == ssb_pkg::SSB_PWR_RUN),
        .level_in (pins.remote_int),
        .request  (remote_request)
    );

    // Shared pins are open-drain: drive only low, release for high
    // receive/data and transmit/clock pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_sda_oe <= 1'b0;
            tx_scl_oe <= 1'b0;
        end else if (two_wire_mode == ssb_pkg::SSB_TWO_WIRE) begin
            rx_sda_oe <= sda_drive_low;
            tx_scl_oe <= scl_drive_low;
        end else begin
            rx_sda_oe <= 1'b0;
            tx_scl_oe <= ~uart_tx;
        end
    end
    assign rx_sda_out = 1'b0;
    assign tx_scl_out = 1'b0;

    // Pin readback; idle level high keeps the UART receiver quiet
    assign uart_rx  = (two_wire_mode == ssb_pkg::SSB_UART) ? pins.rx_sda : 1'b1;
    assign sda_seen = pins.rx_sda;
    assign scl_seen = pins.tx_scl;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_lane_gate;
        @(posedge lvds_clock_in) disable iff (rst)
        (link_cfg.powered && !link_cfg.four_lane) |=>
            (payload_word[ssb_pkg::BIT_CTRL_TWO:ssb_pkg::FOUR_LO] == 8'h00);
    endproperty
    a_lane_gate: assert property (p_lane_gate)
        else $error("lane four or control bits passed in three-lane mode");

    property p_ctrl_zero;
        @(posedge lvds_clock_in) disable iff (rst)
        (link_cfg.powered && !link_cfg.audio_on) |=>
            (payload_word[ssb_pkg::BIT_CTRL_ZERO]
             == $past(audio_data_or_ctrl_zero));
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("shared audio pin not sampled as control");

    property p_zero_encrypt;
        @(posedge lvds_clock_in) disable iff (rst)
        (link_cfg.powered && link_cfg.encrypt_on) |=>
            encrypt_mask[ssb_pkg::BIT_CTRL_ZERO];
    endproperty
    a_zero_encrypt: assert property (p_zero_encrypt)
        else $error("control zero bit not tagged for encryption");

    property p_ctrl_one;
        @(posedge lvds_clock_in) disable iff (rst)
        (link_cfg.powered && link_cfg.four_lane && !link_cfg.use_reserved)
            |=> (payload_word[ssb_pkg::BIT_CTRL_ONE] == $past(ctrl_in_one));
    endproperty
    a_ctrl_one: assert property (p_ctrl_one)
        else $error("control one not placed in bit 27");

    property p_ctrl_plain;
        @(posedge lvds_clock_in) disable iff (rst)
        payload_valid |-> (encrypt_mask[ssb_pkg::BIT_CTRL_TWO:
                                        ssb_pkg::BIT_CTRL_ONE] == 2'b00);
    endproperty
    a_ctrl_plain: assert property (p_ctrl_plain)
        else $error("control one or two tagged for encryption");

    property p_ctrl_two;
        @(posedge lvds_clock_in) disable iff (rst)
        (link_cfg.powered && link_cfg.four_lane) |=>
            (payload_word[ssb_pkg::BIT_CTRL_TWO] == $past(ctrl_in_two));
    endproperty
    a_ctrl_two: assert property (p_ctrl_two)
        else $error("control two not placed in bit 28");

    property p_strap_hold;
        @(posedge core_clk) disable iff (rst)
        (pwr_state != ssb_pkg::SSB_PWR_CAPTURE) |=> $stable(spread_enable);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("spread strap changed outside capture");

    property p_spread_depth;
        @(posedge core_clk) disable iff (rst)
        spread_enable |-> (spread_amount == ssb_pkg::SPREAD_DEPTH);
    endproperty
    a_spread_depth: assert property (p_spread_depth)
        else $error("spread depth wrong while enabled");

    property p_fault_release;
        @(posedge core_clk) disable iff (rst)
        !pins.powered |=> !line_fault_n_oe;
    endproperty
    a_fault_release: assert property (p_fault_release)
        else $error("fault pin driven during power-down");

    property p_fault_drive;
        @(posedge core_clk) disable iff (rst)
        (pins.powered && pins.fault) |=> line_fault_n_oe;
    endproperty
    a_fault_drive: assert property (p_fault_drive)
        else $error("line fault not reported");

    property p_request_low;
        @(posedge core_clk) disable iff (rst)
        (pwr_state == ssb_pkg::SSB_PWR_DOWN) |=> ##1 !remote_request;
    endproperty
    a_request_low: assert property (p_request_low)
        else $error("remote request high during power-down");

    property p_request_toggle;
        @(posedge core_clk) disable iff (rst)
        (pwr_state == ssb_pkg::SSB_PWR_RUN && $past(pwr_state)
         == ssb_pkg::SSB_PWR_RUN && $changed(pins.remote_int)
         && pins.powered)
            |=> (remote_request != $past(remote_request));
    endproperty
    a_request_toggle: assert property (p_request_toggle)
        else $error("remote edge did not invert request");

    property p_two_wire;
        @(posedge core_clk) disable iff (rst)
        (two_wire_mode == ssb_pkg::SSB_TWO_WIRE) |=>
            (rx_sda_oe == $past(sda_drive_low)
             && tx_scl_oe == $past(scl_drive_low));
    endproperty
    a_two_wire: assert property (p_two_wire)
        else $error("two-wire pins not following master");

    property p_uart_tx;
        @(posedge core_clk) disable iff (rst)
        (two_wire_mode == ssb_pkg::SSB_UART) |=>
            (tx_scl_oe == !$past(uart_tx));
    endproperty
    a_uart_tx: assert property (p_uart_tx)
        else $error("UART transmit not on shared pin");

    c_four_lane: cover property (@(posedge lvds_clock_in) disable iff (rst)
        link_cfg.four_lane && payload_valid);
    c_restart: cover property (@(posedge core_clk) disable iff (rst)
        pwr_state == ssb_pkg::SSB_PWR_CAPTURE && pins.strap);
    c_request: cover property (@(posedge core_clk) disable iff (rst)
        $rose(remote_request));
    c_fault: cover property (@(posedge core_clk) disable iff (rst)
        $rose(line_fault_n_oe));

endmodule : ssb_sideband

// file: sim/ssb_far_side.sv
// Far side model: LVDS source with its clock, pulled-up shared pins
module ssb_far_side (
    // Link clock and lane data
    output logic        lvds_clock_in,
    output logic [20:0] lane_word,
    output logic [6:0]  lvds_lane_four_in,
    output logic        audio_data_or_ctrl_zero,
    output logic        ctrl_in_one,
    output logic        ctrl_in_two,
    // Open-drain shared pins
    input  wire logic   rx_sda_oe,
    input  wire logic   tx_scl_oe,
    input  wire logic   peer_sda_low,
    output logic        rx_sda_in,
    output logic        tx_scl_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] pattern = 32'h0000_0000;
    // LVDS clock runs free, phase unrelated to the core clock
    initial begin
        lvds_clock_in = 1'b0;
        #7;
        forever #24 lvds_clock_in = ~lvds_clock_in;
    end
    // source data moves away from the sampling edge
    always @(negedge lvds_clock_in) pattern <= pattern + 32'h9E37_79B1;
    assign lane_word = pattern[20:0];
    assign lvds_lane_four_in = pattern[27:21];
    assign audio_data_or_ctrl_zero = pattern[29];
    assign ctrl_in_one = pattern[30];
    assign ctrl_in_two = pattern[31];
    // Pull-ups hold the lines high unless a party pulls low
    assign rx_sda_in = !(rx_sda_oe || peer_sda_low);
    assign tx_scl_in = !tx_scl_oe;
endmodule : ssb_far_side

// file: sim/ssb_sideband_bench.sv
// Self-checking bench of the sideband pin logic
module ssb_sideband_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst, lvds_clock_in, power_down_n;
    logic [20:0] lane_word;
    logic [6:0] lvds_lane_four_in;
    logic audio_data_or_ctrl_zero, ctrl_in_one, ctrl_in_two;
    logic bus_width_select, audio_enable, encrypt_enable;
    logic use_reserved_bit, spread_spectrum_strap, payload_valid;
    logic [29:0] payload_word, encrypt_mask, exp_w;
    logic four_lane_active, spread_enable, two_wire_mode, uart_tx;
    logic [3:0] spread_amount;
    logic uart_rx, sda_drive_low, scl_drive_low, sda_seen, scl_seen;
    logic rx_sda_in, rx_sda_oe, tx_scl_in, tx_scl_oe, peer_sda_low;
    logic line_fault_detect, line_fault_n_oe, remote_int_in;
    logic remote_request, chk_on = 1'b0, req;
    logic [3:0] cfg [4] = '{4'hA, 4'h9, 4'h6, 4'h0};
    int bad_count = 0, checked = 0, ticks = 0;

    ssb_sideband ssb_sideband_inst (.core_clk, .rst, .lvds_clock_in,
        .lane_word, .lvds_lane_four_in, .audio_data_or_ctrl_zero,
        .ctrl_in_one, .ctrl_in_two, .bus_width_select, .audio_enable,
        .encrypt_enable, .use_reserved_bit, .power_down_n,
        .spread_spectrum_strap, .payload_word, .encrypt_mask,
        .payload_valid, .four_lane_active, .spread_enable, .spread_amount,
        .two_wire_mode, .uart_tx, .uart_rx, .sda_drive_low, .scl_drive_low,
        .sda_seen, .scl_seen, .rx_sda_in, .rx_sda_out(), .rx_sda_oe,
        .tx_scl_in, .tx_scl_out(), .tx_scl_oe, .line_fault_detect,
        .line_fault_n_out(), .line_fault_n_oe, .remote_int_in,
        .remote_request);
    ssb_far_side ssb_far_side_inst (.lvds_clock_in, .lane_word,
        .lvds_lane_four_in, .audio_data_or_ctrl_zero, .ctrl_in_one,
        .ctrl_in_two, .rx_sda_oe, .tx_scl_oe, .peer_sda_low, .rx_sda_in,
        .tx_scl_in);

    always #20 core_clk = ~core_clk;

    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [29:0] got, input logic [29:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // Word the link should carry for the pins sampled at an edge
    function automatic logic [29:0] word_of();
        logic [29:0] w;
        w = {9'h000, lane_word};
        if (bus_width_select) begin
            w[26:21] = lvds_lane_four_in[5:0];
            w[27] = use_reserved_bit ? lvds_lane_four_in[6] : ctrl_in_one;
            w[28] = ctrl_in_two;
        end
        w[29] = !audio_enable && audio_data_or_ctrl_zero;
        return w;
    endfunction : word_of

    // Expectation taken on the same edge the design samples
    always @(posedge lvds_clock_in) exp_w <= word_of();
    // Payload compared mid-cycle, where it is settled
    always @(negedge lvds_clock_in) if (chk_on) begin
        cmp(payload_word, exp_w);
        // Lanes follow encryption, lane four only when carried
        cmp(encrypt_mask, {encrypt_enable, 2'h0,
            {6{encrypt_enable && bus_width_select}},
            {21{encrypt_enable}}});
    end

    // Hang guard, well above the length of the sequence
    always @(posedge core_clk) begin
        ticks++;
        if (ticks == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        {rst, spread_spectrum_strap, bus_width_select, encrypt_enable} = 4'hF;
        {audio_enable, use_reserved_bit, power_down_n, two_wire_mode} = 4'h0;
        {uart_tx, sda_drive_low, scl_drive_low, peer_sda_low} = 4'h8;
        {line_fault_detect, remote_int_in, req} = 3'h0;
        cyc(6);
        rst = 1'b0;
        line_fault_detect = 1'b1;
        cyc(5);
        cmp({29'h0, remote_request}, 30'h0);
        cmp({29'h0, line_fault_n_oe}, 30'h0);
        power_down_n = 1'b1;
        cyc(6);
        cmp({29'h0, spread_enable}, 30'h1);
        cmp({26'h0, spread_amount}, {26'h0, ssb_pkg::SPREAD_DEPTH});
        cmp({29'h0, line_fault_n_oe}, 30'h1);
        {line_fault_detect, spread_spectrum_strap} = 2'h0;
        cyc(5);
        cmp({29'h0, spread_enable}, 30'h1);
        cmp({29'h0, line_fault_n_oe}, 30'h0);
        for (int i = 0; i < 3; i++) begin
            remote_int_in = ~remote_int_in;
            req = ~req;
            cyc(4);
            cmp({29'h0, remote_request}, {29'h0, req});
        end
        for (int k = 0; k < 4; k++) begin
            chk_on = 1'b0;
            // bus width and mode levels from the table
            {bus_width_select, audio_enable, encrypt_enable, use_reserved_bit}
                = cfg[k];
            cyc(4);
            chk_on = 1'b1;
            cyc(10);
            cmp({29'h0, four_lane_active}, {29'h0, bus_width_select});
            cmp({29'h0, payload_valid}, 30'h1);
        end
        chk_on = 1'b0;
        {uart_tx, peer_sda_low} = 2'h1;
        cyc(3);
        cmp({28'h0, tx_scl_oe, uart_rx}, 30'h2);
        {uart_tx, peer_sda_low, two_wire_mode, sda_drive_low} = 4'hB;
        cyc(3);
        cmp({27'h0, rx_sda_oe, sda_seen, uart_rx}, 30'h5);
        {sda_drive_low, scl_drive_low} = 2'h1;
        cyc(3);
        cmp({28'h0, tx_scl_oe, scl_seen}, 30'h2);
        {scl_drive_low, peer_sda_low} = 2'h1;
        cyc(3);
        cmp({27'h0, tx_scl_oe, scl_seen, sda_seen}, 30'h2);
        line_fault_detect = 1'b1;
        power_down_n = 1'b0;
        cyc(5);
        cmp({28'h0, remote_request, line_fault_n_oe}, 30'h0);
        remote_int_in = ~remote_int_in;
        cyc(4);
        power_down_n = 1'b1;
        cyc(6);
        cmp({29'h0, remote_request}, 30'h0);
        cmp({29'h0, spread_enable}, 30'h0);
        cmp({26'h0, spread_amount}, {26'h0, ssb_pkg::SPREAD_NONE});
        report_and_stop();
    end
endmodule : ssb_sideband_bench
